/* File: src/flyback_seq_pkg.sv */
// constants and types for the flyback supervisory sequencer
// Behaviour
// - line low for blanking time stops drive
// - brown-out recovery resets latches, then restarts
// - supply below inhibit selects reduced start current
// - start current on until supply start level
// - every start begins with soft-start ramp
// - peak limit sets error flag, runs overload timer
// - auto-recovery holds drive off then retries
// - latching option latches off validated overload
// - fault-pin overvoltage latches device off
// - fault-pin low level latches overtemperature fault
// - feedback at lockout level skips first valley
// - falling feedback steps valley up to sixth
// - foldback level freezes setpoint, lowers frequency
// - freeze-pin variant: setpoint is quarter level
// - never below clamp frequency; skip instead
// - jitter only at high line, not foldback
// - remote input high enters deep sleep
// - mains loss turns on start current source
// - restarts, except those after deep sleep, pull remote input low for discharge
// - overtemperature ignored during soft-start
package flyback_seq_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BLANK_MS = 50;
    localparam int unsigned SSTART_MS = 4;
    localparam int unsigned OVLD_MS = 160;
    localparam int unsigned AREC_MS = 2000;
    localparam int unsigned DISCH_MS = 100;
    localparam int unsigned BLANK_CYC = CLK_HZ / 1000 * BLANK_MS;
    localparam int unsigned SSTART_CYC = CLK_HZ / 1000 * SSTART_MS;
    localparam int unsigned OVLD_CYC = CLK_HZ / 1000 * OVLD_MS;
    localparam int unsigned AREC_CYC = CLK_HZ / 1000 * AREC_MS;
    localparam int unsigned DISCH_CYC = CLK_HZ / 1000 * DISCH_MS;
    localparam int unsigned TMR_W = 26;
    localparam int unsigned SS_STEPS = 63;
    localparam logic [5:0] SS_MAX = 6'h3f;
    localparam logic [2:0] VALLEY_FIRST = 3'h1;
    localparam logic [2:0] VALLEY_LAST = 3'h6;
    localparam logic [7:0] LEVEL_ZERO = 8'h00;
    localparam int unsigned SYNC_N = 10;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_CHARGE = 3'b001,
        ST_SOFT = 3'b010,
        ST_RUN = 3'b011,
        ST_HOLD = 3'b100,
        ST_LATCH = 3'b101,
        ST_SLEEP = 3'b110,
        ST_BROWN = 3'b111
    } state_t;
endpackage : flyback_seq_pkg

/* File: src/sync_2ff.sv */
// two-stage synchroniser for a bundle of levels
module sync_2ff #(
    parameter int unsigned W = 1
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : sync_2ff

/* File: src/flyback_supervisory_sequencer.sv */
// supervisory and mode-control sequencer for a quasi-resonant flyback
module flyback_supervisory_sequencer #(
    parameter int unsigned BLANK_CYC = flyback_seq_pkg::BLANK_CYC,
    parameter int unsigned SSTART_CYC = flyback_seq_pkg::SSTART_CYC,
    parameter int unsigned OVLD_CYC = flyback_seq_pkg::OVLD_CYC,
    parameter int unsigned AREC_CYC = flyback_seq_pkg::AREC_CYC,
    parameter int unsigned DISCH_CYC = flyback_seq_pkg::DISCH_CYC,
    parameter bit LATCH_OVERLOAD = 1'b0,
    parameter bit JITTER_VARIANT = 1'b0,
    parameter bit FREEZE_VARIANT = 1'b0
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic line_low_i,
    input wire logic supply_inhibit_i,
    input wire logic supply_start_level_i,
    input wire logic peak_limit_i,
    input wire logic fault_high_threshold_i,
    input wire logic fault_low_i,
    input wire logic lockout_level_i,
    input wire logic feedback_falling_i,
    input wire logic foldback_level_i,
    input wire logic freeze_cross_i,
    input wire logic clamp_reached_i,
    input wire logic high_line_i,
    input wire logic remote_sleep_input_i,
    input wire logic mains_loss_input_i,
    input wire logic [7:0] freeze_level_input_i,
    input wire logic drive_request_i,
    output logic gate_drive_output_o,
    output logic full_startup_current_o,
    output logic reduced_startup_current_o,
    output logic [5:0] soft_start_step_o,
    output logic overload_flag_o,
    output logic [2:0] valley_index_o,
    output logic foldback_o,
    output logic skip_cycle_o,
    output logic [7:0] frozen_setpoint_o,
    output logic jitter_en_o,
    output logic deep_sleep_state_o,
    output logic remote_pull_o,
    output logic remote_pull_oe_o,
    output logic latched_o
);
    localparam int unsigned N = flyback_seq_pkg::SYNC_N;
    localparam logic [flyback_seq_pkg::TMR_W-1:0] SS_TICK =
        flyback_seq_pkg::TMR_W'(SSTART_CYC / flyback_seq_pkg::SS_STEPS);

    logic [N-1:0] raw;
    logic [N-1:0] s;
    logic lo_line, inh, son, plim, fhi, flo, lock, fold, clamp, remote_sleep_input;
    flyback_seq_pkg::state_t state_q, state_d;
    logic [flyback_seq_pkg::TMR_W-1:0] tmr_q, blank_q, ovld_q, disch_q, sstick_q;
    logic brown_q, latch_q, ovld_err_q, first_q, sleep_restart_q;

    assign raw = {line_low_i, supply_inhibit_i, supply_start_level_i, peak_limit_i,
                  fault_high_threshold_i, fault_low_i, lockout_level_i,
                  foldback_level_i, clamp_reached_i, remote_sleep_input_i};

    sync_2ff #(.W(N)) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(raw),
        .sync_o(s)
    );
    assign {lo_line, inh, son, plim, fhi, flo, lock, fold, clamp, remote_sleep_input} = s;

    function automatic logic tmr_done(input logic [flyback_seq_pkg::TMR_W-1:0] t,
                                      input int unsigned lim);
        tmr_done = (t >= flyback_seq_pkg::TMR_W'(lim - 1));
    endfunction : tmr_done

    function automatic logic charging(input flyback_seq_pkg::state_t st);
        charging = (st == flyback_seq_pkg::ST_CHARGE) || (st == flyback_seq_pkg::ST_BROWN);
    endfunction : charging

    // brown-out blanking counter
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            blank_q <= '0;
            brown_q <= 1'b0;
        end else if (!lo_line) begin
            blank_q <= '0;
            brown_q <= 1'b0;
        end else if (tmr_done(blank_q, BLANK_CYC)) begin
            brown_q <= 1'b1;
        end else begin
            blank_q <= blank_q + 1'b1;
        end
    end

    wire running = (state_q == flyback_seq_pkg::ST_SOFT) ||
                   (state_q == flyback_seq_pkg::ST_RUN);
    wire fault_now = fhi || (flo && state_q == flyback_seq_pkg::ST_RUN);
    wire ovld_valid = ovld_err_q && tmr_done(ovld_q, OVLD_CYC);

    // overload flag and timer
    // timer parks at expiry; leaving the running states clears both
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !running) begin
            ovld_err_q <= 1'b0;
            ovld_q <= '0;
        end else if (plim || ovld_err_q) begin
            ovld_err_q <= 1'b1;
            ovld_q <= ovld_valid ? ovld_q : ovld_q + 1'b1;
        end
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            flyback_seq_pkg::ST_OFF:
                // wait one edge so the synchronised levels are valid
                if (!first_q) begin
                    state_d = flyback_seq_pkg::ST_CHARGE;
                end
            flyback_seq_pkg::ST_CHARGE: begin
                if (brown_q) begin
                    state_d = flyback_seq_pkg::ST_BROWN;
                end else if (fhi) begin
                    state_d = flyback_seq_pkg::ST_LATCH;
                end else if (son && !latch_q) begin
                    state_d = flyback_seq_pkg::ST_SOFT;
                end
            end
            flyback_seq_pkg::ST_SOFT, flyback_seq_pkg::ST_RUN: begin
                if (brown_q) begin
                    state_d = flyback_seq_pkg::ST_BROWN;
                end else if (fault_now) begin
                    state_d = flyback_seq_pkg::ST_LATCH;
                end else if (remote_sleep_input) begin
                    state_d = flyback_seq_pkg::ST_SLEEP;
                end else if (ovld_valid) begin
                    state_d = LATCH_OVERLOAD ? flyback_seq_pkg::ST_LATCH
                                             : flyback_seq_pkg::ST_HOLD;
                end else if (state_q == flyback_seq_pkg::ST_SOFT &&
                             tmr_done(tmr_q, SSTART_CYC)) begin
                    state_d = flyback_seq_pkg::ST_RUN;
                end
            end
            flyback_seq_pkg::ST_HOLD: begin
                if (brown_q) begin
                    state_d = flyback_seq_pkg::ST_BROWN;
                end else if (fhi) begin
                    state_d = flyback_seq_pkg::ST_LATCH;
                end else if (tmr_done(tmr_q, AREC_CYC)) begin
                    state_d = flyback_seq_pkg::ST_SOFT;
                end
            end
            flyback_seq_pkg::ST_LATCH:
                if (brown_q) begin
                    state_d = flyback_seq_pkg::ST_BROWN;
                end
            flyback_seq_pkg::ST_SLEEP:
                if (!remote_sleep_input) begin
                    state_d = flyback_seq_pkg::ST_CHARGE;
                end
            flyback_seq_pkg::ST_BROWN:
                if (!lo_line) begin
                    state_d = flyback_seq_pkg::ST_CHARGE;
                end
            default:
                state_d = flyback_seq_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_q <= flyback_seq_pkg::ST_OFF;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            tmr_q <= (state_d != state_q) ? '0 : tmr_q + 1'b1;
        end
    end

    // fault latch, cleared only by general reset on line recovery
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            latch_q <= 1'b0;
        end else if (state_d == flyback_seq_pkg::ST_LATCH) begin
            latch_q <= 1'b1;
        end else if (state_q == flyback_seq_pkg::ST_BROWN && !lo_line) begin
            latch_q <= 1'b0;
        end
    end

    // soft-start ramp steps
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sstick_q <= '0;
            soft_start_step_o <= 6'h00;
        end else if (state_q != flyback_seq_pkg::ST_SOFT) begin
            sstick_q <= '0;
            soft_start_step_o <= (state_q == flyback_seq_pkg::ST_RUN) ?
                                 flyback_seq_pkg::SS_MAX : 6'h00;
        end else if (sstick_q >= SS_TICK) begin
            sstick_q <= '0;
            if (soft_start_step_o != flyback_seq_pkg::SS_MAX) begin
                soft_start_step_o <= soft_start_step_o + 6'h01;
            end
        end else begin
            sstick_q <= sstick_q + 1'b1;
        end
    end

    // remote discharge pull on non-sleep restarts
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            disch_q <= '0;
            sleep_restart_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
            if (state_q == flyback_seq_pkg::ST_SLEEP) begin
                sleep_restart_q <= 1'b1;
            end else if (state_q == flyback_seq_pkg::ST_RUN) begin
                sleep_restart_q <= 1'b0;
            end
            if (state_d == flyback_seq_pkg::ST_SOFT && state_q != flyback_seq_pkg::ST_SOFT &&
                !sleep_restart_q) begin
                disch_q <= flyback_seq_pkg::TMR_W'(DISCH_CYC);
            end else if (disch_q != '0) begin
                disch_q <= disch_q - 1'b1;
            end
        end
    end

    // outputs
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            gate_drive_output_o <= 1'b0;
            full_startup_current_o <= 1'b0;
            reduced_startup_current_o <= 1'b0;
            overload_flag_o <= 1'b0;
            deep_sleep_state_o <= 1'b0;
            remote_pull_o <= 1'b0;
            remote_pull_oe_o <= 1'b0;
            latched_o <= 1'b0;
        end else begin
            // drive follows the request one cycle late; skip masks it
            gate_drive_output_o <= running && drive_request_i && !skip_cycle_o;
            full_startup_current_o <= mains_loss_input_i ||
                (charging(state_q) && !son && !inh);
            reduced_startup_current_o <= !mains_loss_input_i && inh &&
                charging(state_q);
            overload_flag_o <= ovld_err_q;
            deep_sleep_state_o <= (state_q == flyback_seq_pkg::ST_SLEEP);
            remote_pull_o <= 1'b0;
            remote_pull_oe_o <= (disch_q != '0);
            latched_o <= latch_q;
        end
    end

    // next foldback level, so jitter drops on the same edge
    wire fold_next = FREEZE_VARIANT ? freeze_cross_i : fold;

    // regime selection
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !running) begin
            valley_index_o <= flyback_seq_pkg::VALLEY_FIRST;
            foldback_o <= 1'b0;
            skip_cycle_o <= 1'b0;
            jitter_en_o <= 1'b0;
            frozen_setpoint_o <= flyback_seq_pkg::LEVEL_ZERO;
        end else begin
            if (!lock) begin
                valley_index_o <= flyback_seq_pkg::VALLEY_FIRST;
            end else if (valley_index_o == flyback_seq_pkg::VALLEY_FIRST) begin
                valley_index_o <= valley_index_o + 3'h1;
            end else if (feedback_falling_i &&
                         valley_index_o != flyback_seq_pkg::VALLEY_LAST) begin
                valley_index_o <= valley_index_o + 3'h1;
            end
            foldback_o <= fold_next;
            if (!foldback_o) begin
                frozen_setpoint_o <= FREEZE_VARIANT ? {2'b00, freeze_level_input_i[7:2]}
                                                    : flyback_seq_pkg::LEVEL_ZERO;
            end
            skip_cycle_o <= foldback_o && clamp;
            jitter_en_o <= JITTER_VARIANT && high_line_i && !fold_next;
        end
    end
endmodule : flyback_supervisory_sequencer

/* File: verif/flyback_seq_monitor.sv */
// port-level assertion checker for the flyback sequencer
module flyback_seq_monitor (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic drive_request_i,
    input wire logic fault_high_threshold_i,
    input wire logic mains_loss_input_i,
    input wire logic gate_drive_output_o,
    input wire logic full_startup_current_o,
    input wire logic reduced_startup_current_o,
    input wire logic [2:0] valley_index_o,
    input wire logic foldback_o,
    input wire logic jitter_en_o,
    input wire logic deep_sleep_state_o,
    input wire logic latched_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_ovp_held;
        fault_high_threshold_i [*3];
    endsequence
    sequence s_loss_held;
        mains_loss_input_i [*2];
    endsequence
    property p_latch_quiet;
        latched_o |-> !gate_drive_output_o;
    endproperty
    a_latch_quiet: assert property (p_latch_quiet) else $error("drive while latched");
    property p_sleep_quiet;
        deep_sleep_state_o |-> !gate_drive_output_o;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("drive in sleep");
    property p_valley_range;
        valley_index_o >= 3'h1 && valley_index_o <= 3'h6;
    endproperty
    a_valley_range: assert property (p_valley_range) else $error("valley out of range");
    property p_one_current;
        !(full_startup_current_o && reduced_startup_current_o);
    endproperty
    a_one_current: assert property (p_one_current) else $error("both currents on");
    property p_jit_fold;
        foldback_o |-> !jitter_en_o;
    endproperty
    a_jit_fold: assert property (p_jit_fold) else $error("jitter in foldback");
    property p_gate_cause;
        $rose(gate_drive_output_o) |-> $past(drive_request_i);
    endproperty
    a_gate_cause: assert property (p_gate_cause) else $error("gate without request");
    property p_ovp;
        s_ovp_held |-> ##[0:3] latched_o;
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not latched");
    property p_loss;
        s_loss_held |-> ##[0:2] full_startup_current_o;
    endproperty
    a_loss: assert property (p_loss) else $error("no discharge current");
endmodule : flyback_seq_monitor

bind flyback_supervisory_sequencer flyback_seq_monitor mon_u (.*);

/* File: verif/flyback_stage_model.sv */
// power stage model: supply rail charge and remote opto pin
module flyback_stage_model (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic full_i,
    input wire logic reduced_i,
    input wire logic pull_oe_i,
    input wire logic opto_on_i,
    output logic inhibit_o,
    output logic start_level_o,
    output logic remote_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int vcc = 0;
    always @(posedge clock_i) begin
        if (!resetn_i)
            vcc <= 0;
        else if (vcc < 60)
            vcc <= vcc + (full_i ? 4 : (reduced_i ? 1 : 0));
    end
    assign inhibit_o = vcc < 8;
    assign start_level_o = vcc >= 40;
    // pin rises once the opto lets go
    assign remote_o = pull_oe_i ? 1'b0 : !opto_on_i;
endmodule : flyback_stage_model

/* File: verif/test_flyback_supervisory_sequencer.sv */
// self-checking bench for the flyback sequencer
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_flyback_supervisory_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BL = 200, SS = 100, OV = 200, AR = 300, DI = 150;
    int n_mismatch = 0, check_count = 0;
    logic clock_i = 0, resetn_i = 0, line_low_i = 0, supply_inhibit_i, supply_start_level_i;
    logic peak_limit_i = 0, fault_high_threshold_i = 0, fault_low_i = 0, lockout_level_i = 0;
    logic feedback_falling_i = 0, foldback_level_i = 0, freeze_cross_i = 0;
    logic clamp_reached_i = 0, high_line_i = 0, remote_sleep_input_i, mains_loss_input_i = 0;
    logic [7:0] freeze_level_input_i = 8'h00;
    logic drive_request_i = 1, opto_on = 1;
    logic gate_drive_output_o, full_startup_current_o, reduced_startup_current_o;
    logic overload_flag_o, foldback_o, skip_cycle_o, jitter_en_o, deep_sleep_state_o;
    logic remote_pull_o, remote_pull_oe_o, latched_o;
    logic [5:0] soft_start_step_o;
    logic [2:0] valley_index_o;
    logic [7:0] frozen_setpoint_o;
    logic alt_gate, alt_latched, alt_fold;
    logic [7:0] alt_frozen;
    flyback_supervisory_sequencer #(.BLANK_CYC(BL), .SSTART_CYC(SS), .OVLD_CYC(OV),
        .AREC_CYC(AR), .DISCH_CYC(DI), .JITTER_VARIANT(1'b1)) dut_u (.*);
    // latching, freeze-input variant on the same stimulus
    flyback_supervisory_sequencer #(.BLANK_CYC(BL), .SSTART_CYC(SS), .OVLD_CYC(OV),
        .AREC_CYC(AR), .DISCH_CYC(DI), .LATCH_OVERLOAD(1'b1),
        .FREEZE_VARIANT(1'b1)) dut_alt_u (
        .gate_drive_output_o(alt_gate), .full_startup_current_o(),
        .reduced_startup_current_o(), .soft_start_step_o(), .overload_flag_o(),
        .valley_index_o(), .foldback_o(alt_fold), .skip_cycle_o(),
        .frozen_setpoint_o(alt_frozen), .jitter_en_o(), .deep_sleep_state_o(),
        .remote_pull_o(), .remote_pull_oe_o(), .latched_o(alt_latched), .*);
    flyback_stage_model stage_u (.clock_i(clock_i), .resetn_i(resetn_i),
        .full_i(full_startup_current_o), .reduced_i(reduced_startup_current_o),
        .pull_oe_i(remote_pull_oe_o), .opto_on_i(opto_on), .inhibit_o(supply_inhibit_i),
        .start_level_o(supply_start_level_i), .remote_o(remote_sleep_input_i));
    initial forever #25 clock_i = ~clock_i;
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick
    function automatic logic hit(input int s);
        case (s)
            0: return full_startup_current_o;
            1: return !full_startup_current_o && !reduced_startup_current_o;
            2: return soft_start_step_o == flyback_seq_pkg::SS_MAX;
            3: return gate_drive_output_o;
            4: return !gate_drive_output_o;
            5: return deep_sleep_state_o;
            default: return latched_o;
        endcase
    endfunction : hit
    task automatic wait_on(input int s, input int n);
        int k;
        for (k = 0; k < n && hit(s) !== 1'b1; k++) @(posedge clock_i);
        if (k == n) begin
            $display("[FAIL] wait %0d exp 1 got 0", s);
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_on
    task automatic t_start();
        tick(4);
        `CHK("reduced", 1'b1, reduced_startup_current_o)
        wait_on(0, 40);
        wait_on(1, 60);
        tick(2);
        `CHK("pull_oe", 1'b1, remote_pull_oe_o)
        `CHK("ss_low", 1'b1, soft_start_step_o < flyback_seq_pkg::SS_MAX)
        wait_on(2, SS + 10);
        wait_on(3, 20);
        `CHK("pull_lvl", 1'b0, remote_pull_o)
        drive_request_i <= 0;
        tick(3);
        `CHK("gate_req", 1'b0, gate_drive_output_o)
        drive_request_i <= 1;
    endtask : t_start
    task automatic t_valley();
        high_line_i <= 1;
        freeze_level_input_i <= 8'hc8;
        lockout_level_i <= 1;
        tick(4);
        `CHK("jit_hi", 1'b1, jitter_en_o)
        `CHK("valley2", 3'h2, valley_index_o)
        repeat (8) begin
            feedback_falling_i <= 1;
            tick(1);
            feedback_falling_i <= 0;
            tick(1);
        end
        tick(2);
        `CHK("valley6", 3'h6, valley_index_o)
        foldback_level_i <= 1;
        freeze_cross_i <= 1;
        tick(4);
        `CHK("fold", 1'b1, foldback_o)
        `CHK("jit_fold", 1'b0, jitter_en_o)
        `CHK("alt_fold", 1'b1, alt_fold)
        `CHK("alt_frozen", 8'h32, alt_frozen)
        `CHK("frozen_fixed", 8'h00, frozen_setpoint_o)
        freeze_level_input_i <= 8'h40;
        clamp_reached_i <= 1;
        tick(4);
        `CHK("skip", 1'b1, skip_cycle_o)
        `CHK("alt_hold", 8'h32, alt_frozen)
        clamp_reached_i <= 0;
        foldback_level_i <= 0;
        freeze_cross_i <= 0;
        lockout_level_i <= 0;
        high_line_i <= 0;
        tick(4);
        `CHK("jit_lo", 1'b0, jitter_en_o)
    endtask : t_valley
    task automatic t_overload();
        peak_limit_i <= 1;
        tick(5);
        `CHK("ovl_flag", 1'b1, overload_flag_o)
        tick(OV - 20);
        `CHK("ovl_early", 1'b1, gate_drive_output_o)
        wait_on(4, 40);
        peak_limit_i <= 0;
        tick(AR - 40);
        `CHK("hold", 1'b0, gate_drive_output_o)
        `CHK("alt_latch", 1'b1, alt_latched)
        wait_on(3, 100);
        `CHK("alt_no_retry", 1'b0, alt_gate)
        `CHK("ss_again", 1'b1, soft_start_step_o < flyback_seq_pkg::SS_MAX)
        wait_on(2, SS + 10);
    endtask : t_overload
    task automatic t_brown(input int on_latch);
        line_low_i <= 1;
        tick(BL - 20);
        if (on_latch == 0)
            `CHK("bo_early", 1'b1, gate_drive_output_o)
        wait_on(4, 40);
        tick(30);
        line_low_i <= 0;
        wait_on(3, 60);
        `CHK("unlatched", 1'b0, latched_o)
        `CHK("alt_unlatched", 1'b0, alt_latched)
        `CHK("bo_pull", 1'b1, remote_pull_oe_o)
    endtask : t_brown
    task automatic t_fault();
        for (int i = 0; i < 2; i++) begin
            if (i == 1) begin
                fault_low_i <= 1;
                tick(6);
                `CHK("ot_soft", 1'b0, latched_o)
                fault_low_i <= 0;
            end
            wait_on(2, SS + 10);
            if (i == 1)
                fault_low_i <= 1;
            else
                fault_high_threshold_i <= 1;
            wait_on(6, 10);
            fault_low_i <= 0;
            fault_high_threshold_i <= 0;
            tick(4);
            `CHK("latch_gate", 1'b0, gate_drive_output_o)
            t_brown(1);
        end
        wait_on(2, SS + 10);
    endtask : t_fault
    task automatic t_sleep();
        opto_on <= 0;
        wait_on(5, DI + 20);
        mains_loss_input_i <= 1;
        tick(4);
        `CHK("loss_full", 1'b1, full_startup_current_o)
        mains_loss_input_i <= 0;
        opto_on <= 1;
        wait_on(3, 60);
        `CHK("psm_pull", 1'b0, remote_pull_oe_o)
    endtask : t_sleep
    initial begin
        tick(8);
        resetn_i <= 1;
        t_start();
        t_valley();
        t_overload();
        t_brown(0);
        wait_on(2, SS + 10);
        t_fault();
        t_sleep();
        report_and_stop();
    end
endmodule : test_flyback_supervisory_sequencer
